// ---- common/wrt_pkg.sv ----
`default_nettype none
package wrt_pkg;

	localparam logic [15:0] ADDR_CTRL = 16'h3000;
	localparam logic [15:0] ADDR_CTRL_HI = 16'h3001;
	localparam logic [15:0] ADDR_KICK = 16'h3002;
	localparam logic [15:0] ADDR_COUNT = 16'h3004;
	localparam logic [15:0] ADDR_LOAD = 16'h3008;
	localparam int BYTE_SEL_W = 2;
	localparam int WORD_LSB = 2;

	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_STS_BIT = 1;
	localparam int CTRL_SIM_BIT = 2;
	localparam int CTRL_UNITS_BIT = 3;
	localparam logic [3:0] CTRL_RSVD_RD = 4'h0;

	localparam logic [31:0] COUNT_RST = 32'hffff_ffff;
	localparam logic [31:0] LOAD_RST = 32'hffff_ffff;
	localparam logic [7:0] READ_ZERO = 8'h00;

	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_MS_NS = 1000000;
	localparam int TICK_US_NS = 1000;
	localparam int SIM_CLK_HZ = 1000000;
	localparam int SIM_PERIOD_NS = 1000000000 / SIM_CLK_HZ;
	localparam int MS_CYCLES = TICK_MS_NS / CLK_PERIOD_NS;
	localparam int US_CYCLES = TICK_US_NS / CLK_PERIOD_NS;
	localparam int SIM_CYCLES = SIM_PERIOD_NS / CLK_PERIOD_NS;
	localparam int DIV_W = 16;

	localparam int SYNC_STAGES = 2;
	localparam int REQ_HOLD_CYCLES = 16;
	localparam int HOLD_W = 5;

	typedef enum logic [1:0] {
		ST_ARMED = 2'b01,
		ST_FIRING = 2'b10
	} wrt_state_type;

endpackage
`default_nettype wire

// ---- rtl/wrt_tick_gen.sv ----
`timescale 1ns/1ns
`default_nettype none
module wrt_tick_gen import wrt_pkg::*; #(
	parameter int P_MS_CYCLES = MS_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic i_restart,
	input wire logic i_units_us,
	input wire logic i_sim,
	output logic o_tick
);

	logic [DIV_W-1:0] div;
	wire [DIV_W-1:0] last_sim = DIV_W'(SIM_CYCLES - 1);
	wire [DIV_W-1:0] last_us = DIV_W'(US_CYCLES - 1);
	wire [DIV_W-1:0] last_ms = DIV_W'(P_MS_CYCLES - 1);
	// Speed-up overrides the resolution choice
	wire [DIV_W-1:0] last = i_sim ? last_sim :
		(i_units_us ? last_us : last_ms);
	wire wrap = div >= last;
	// Divider parks at zero while stopped, so it does not toggle
	wire parked = !i_run || i_restart;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || parked || wrap) begin
			div <= '0;
		end else begin
			div <= div + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_tick <= 1'b0;
		end else begin
			o_tick <= !parked && wrap;
		end
	end

endmodule
`default_nettype wire

// ---- rtl/wrt_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module wrt_top import wrt_pkg::*; #(
	parameter int P_MS_CYCLES = MS_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_por_n,
	input wire logic [15:0] i_addr,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_wr_blocked,
	output logic o_sys_reset_req,
	output logic o_reset_event,
	output logic o_count_running
);

	function automatic logic hit_word(input logic [15:0] a,
		input logic [15:0] base);
		return a[15:WORD_LSB] == base[15:WORD_LSB];
	endfunction

	function automatic logic [31:0] put_byte(input logic [31:0] w,
		input logic [BYTE_SEL_W-1:0] sel, input logic [7:0] b);
		logic [31:0] r;
		r = w;
		r[{sel, 3'b000} +: 8] = b;
		return r;
	endfunction

	function automatic logic [7:0] get_byte(input logic [31:0] w,
		input logic [BYTE_SEL_W-1:0] sel);
		return w[{sel, 3'b000} +: 8];
	endfunction

	logic en;
	logic sim;
	logic units;
	logic sts;
	logic [31:0] load;
	logic [31:0] count;
	logic [31:0] snap;
	logic [SYNC_STAGES-1:0] en_pipe;
	logic [SYNC_STAGES-1:0] kick_pipe;
	logic [HOLD_W-1:0] hold;
	wrt_state_type state;
	wrt_state_type next_state;
	logic [31:0] next_count;
	logic [7:0] next_rdata;
	logic tick;

	wire [BYTE_SEL_W-1:0] bsel = i_addr[BYTE_SEL_W-1:0];

	// While the flag is up only the control byte may be written, and
	// then only its clear bit acts, so software can always recover
	wire host_wr = i_wr && (!sts || i_addr == ADDR_CTRL);
	wire wr_ctrl = host_wr && i_addr == ADDR_CTRL;
	wire wr_ctrl_fields = wr_ctrl && !sts;
	wire wr_kick = host_wr && i_addr == ADDR_KICK;
	wire wr_load = host_wr && hit_word(i_addr, ADDR_LOAD) && !en;
	wire rd_count_low = i_rd && i_addr == ADDR_COUNT;
	wire clr_sts = wr_ctrl && i_wdata[CTRL_STS_BIT];
	wire [31:0] next_load = put_byte(load, bsel, i_wdata);

	// A reload request is only raised while enable is set
	wire kick_req = wr_kick && en;
	wire en_run = en_pipe[SYNC_STAGES-1];
	wire kick_run = kick_pipe[SYNC_STAGES-1] && en_run;
	wire armed = state == ST_ARMED;
	wire count_step = tick && en_run;
	// Reaching zero ends the interval: load value ticks in all
	wire expire = count_step && count <= 32'd1 && armed;
	wire hold_done = hold == '0;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			en <= 1'b0;
			sim <= 1'b0;
			units <= 1'b0;
		end else if (wr_ctrl_fields) begin
			en <= i_wdata[CTRL_EN_BIT];
			sim <= i_wdata[CTRL_SIM_BIT];
			units <= i_wdata[CTRL_UNITS_BIT];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			load <= LOAD_RST;
		end else if (wr_load) begin
			load <= next_load;
		end
	end

	// Enable and reload pass a short pipeline, as the counter side of
	// a clock crossing would see them
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			en_pipe <= '0;
			kick_pipe <= '0;
		end else begin
			en_pipe <= {en_pipe[SYNC_STAGES-2:0], en};
			kick_pipe <= {kick_pipe[SYNC_STAGES-2:0], kick_req};
		end
	end

	wrt_tick_gen #(
		.P_MS_CYCLES(P_MS_CYCLES)
	) u_tick (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_run(en_run),
		.i_restart(kick_run),
		.i_units_us(units),
		.i_sim(sim),
		.o_tick(tick)
	);

	always_comb begin
		if (wr_load) begin
			next_count = next_load;
		end else if (kick_run || expire) begin
			next_count = load;
		end else if (count_step) begin
			next_count = count - 32'd1;
		end else begin
			next_count = count;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			count <= COUNT_RST;
		end else begin
			count <= next_count;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			snap <= COUNT_RST;
		end else if (rd_count_low) begin
			snap <= count;
		end
	end

	// Reset request stretcher lives on power-on reset only, so the
	// chip reset it provokes cannot cut it short
	always_comb begin
		case (state)
			ST_ARMED: begin
				next_state = expire ? ST_FIRING : ST_ARMED;
			end
			ST_FIRING: begin
				// Stay until held long enough and the chip reset is gone
				next_state = (hold_done && i_rst_n) ? ST_ARMED : ST_FIRING;
			end
			default: begin
				next_state = ST_ARMED;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_por_n) begin
			state <= ST_ARMED;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_por_n) begin
			hold <= '0;
		end else if (expire) begin
			hold <= HOLD_W'(REQ_HOLD_CYCLES - 1);
		end else if (!hold_done) begin
			hold <= hold - 1'b1;
		end
	end

	// Flag is outside the chip reset: a reset that we did not request
	// clears it, ours leaves it standing; a new event beats a clear
	always_ff @(posedge i_clk) begin
		if (!i_por_n) begin
			sts <= 1'b0;
		end else if (expire) begin
			sts <= 1'b1;
		end else if (!i_rst_n && armed) begin
			sts <= 1'b0;
		end else if (clr_sts && i_rst_n) begin
			sts <= 1'b0;
		end
	end

	wire [7:0] ctrl_byte = {CTRL_RSVD_RD, units, sim, sts, en};
	wire [7:0] count_byte = (bsel == '0) ? count[7:0] : get_byte(snap, bsel);

	always_comb begin
		if (i_addr == ADDR_CTRL) begin
			next_rdata = ctrl_byte;
		end else if (i_addr == ADDR_CTRL_HI || i_addr == ADDR_KICK) begin
			next_rdata = READ_ZERO;
		end else if (hit_word(i_addr, ADDR_COUNT)) begin
			next_rdata = count_byte;
		end else if (hit_word(i_addr, ADDR_LOAD)) begin
			next_rdata = get_byte(load, bsel);
		end else begin
			next_rdata = READ_ZERO;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= READ_ZERO;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end
	end

	assign o_wr_blocked = sts;
	assign o_sys_reset_req = state == ST_FIRING;
	assign o_reset_event = sts;
	assign o_count_running = en_run;

	block_wr_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(sts && i_wr && i_addr != ADDR_CTRL) |=> $stable(load) && $stable(en))
		else $error("host write got through while flag set");

	kick_off_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_wr && i_addr == ADDR_KICK && !en) |=> !kick_pipe[0])
		else $error("reload accepted while disabled");

	kick_reload_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(kick_run && !wr_load) |=> count == $past(load))
		else $error("reload strobe did not reload counter");

	fire_req_a: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		expire |=> o_sys_reset_req && sts)
		else $error("underflow without reset request and flag");

	req_hold_a: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		$rose(o_sys_reset_req) |-> o_sys_reset_req [*8])
		else $error("reset request too short");

	sts_keep_a: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		(sts && i_rst_n && !clr_sts) |=> sts)
		else $error("flag lost without a clear");

	sts_clear_a: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		(sts && i_rst_n && clr_sts && !expire) |=> !sts)
		else $error("write one did not clear flag");

	hold_count_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(!en_run && !wr_load) |=> $stable(count))
		else $error("counter moved while disabled");

	en_delay_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		($rose(en) ##1 en) |-> ##1 en_run)
		else $error("enable did not reach counter in time");

	step_one_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(count_step && count > 32'd1 && !wr_load && !kick_run)
		|=> count == $past(count) - 32'd1)
		else $error("counter did not step by one");

	snap_take_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		rd_count_low |=> snap == $past(count))
		else $error("snapshot not taken on low byte read");

	kick_zero_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_KICK) |=> o_rdata == READ_ZERO)
		else $error("reload strobe read nonzero");

	load_lock_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(en && !(i_wr && i_addr == ADDR_CTRL)) |=> $stable(load))
		else $error("load changed while enabled");

	expire_reload_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(expire && !wr_load) |=> count == $past(load))
		else $error("counter not reloaded after underflow");

	tick_gate_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		!en_run |=> !tick)
		else $error("tick while disabled");

	kick_restart_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		kick_run |=> !tick)
		else $error("divider not restarted by reload");

	en_stop_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		($fell(en) ##1 !en) |-> ##1 !en_run)
		else $error("disable did not reach counter in time");

	load_reload_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_wr && hit_word(i_addr, ADDR_LOAD) && !en && !sts)
		|=> count == load)
		else $error("load write did not reload counter");

	snap_upper_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_COUNT + 16'h1)
		|=> o_rdata == $past(snap[15:8]))
		else $error("upper count byte not from snapshot");

	sts_chip_rst_a: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		(!i_rst_n && armed && !expire) |=> !sts)
		else $error("foreign reset left flag set");

	sts_survive_a: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		(sts && !i_rst_n && !armed) |=> sts)
		else $error("own reset wiped the flag");

	req_release_a: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		(o_sys_reset_req && !i_rst_n) |=> o_sys_reset_req)
		else $error("request dropped during chip reset");

	req_stay_a: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		(o_sys_reset_req && !hold_done) |=> o_sys_reset_req)
		else $error("request dropped before hold ended");

	event_clear_a: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		$fell(o_reset_event) |-> $past(clr_sts) || !$past(i_rst_n))
		else $error("event flag fell without a flag clear");

endmodule
`default_nettype wire

// ---- verif/wrt_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench import wrt_pkg::*; ();
	// Short ms divider keeps the run small
	localparam int P = 60;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_por_n = 1'b0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] i_addr = 16'h0000;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] rb;
	logic [7:0] o_rdata;
	logic o_wr_blocked;
	logic o_sys_reset_req;
	logic o_reset_event;
	logic o_count_running;
	int err_total = 0;
	int compares = 0;

	wrt_top #(.P_MS_CYCLES(P)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_por_n(i_por_n), .i_addr(i_addr), .i_wr(i_wr),
		.i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_wr_blocked(o_wr_blocked), .o_sys_reset_req(o_sys_reset_req),
		.o_reset_event(o_reset_event), .o_count_running(o_count_running));

	initial begin
		forever #10 i_clk = ~i_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		d = o_rdata;
	endtask

	task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask

	task automatic wr32(input logic [15:0] a, input logic [31:0] v);
		for (int i = 0; i < 4; i++) begin
			wr(a + 16'(i), v[8*i +: 8]);
		end
	endtask

	// Low byte first, so the count snapshot is taken before the rest
	task automatic chk32(input logic [15:0] a, input logic [31:0] e);
		for (int i = 0; i < 4; i++) begin
			chk_rd(a + 16'(i), e[8*i +: 8]);
		end
	endtask

	task automatic chip_rst();
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		cyc(2);
		i_rst_n <= 1'b1;
	endtask

	task automatic arm(input logic [7:0] ctrl, input logic [31:0] load);
		int n;
		wr(ADDR_CTRL, 8'h00);
		wr32(ADDR_LOAD, load);
		wr(ADDR_CTRL, ctrl);
		n = 0;
		while (o_count_running !== 1'b1 && n < 10) begin
			@(negedge i_clk);
			n++;
		end
		`CHK(o_count_running, 1'b1)
	endtask

	task automatic t_reset_values();
		chk_rd(ADDR_CTRL, 8'h00);
		chk_rd(ADDR_CTRL_HI, 8'h00);
		chk_rd(ADDR_KICK, READ_ZERO);
		chk32(ADDR_COUNT, COUNT_RST);
		chk32(ADDR_LOAD, LOAD_RST);
		chk_rd(16'h300c, 8'h00);
		`CHK(o_sys_reset_req, 1'b0)
		`CHK(o_count_running, 1'b0)
	endtask

	task automatic t_counting();
		arm(8'h09, 32'h0000_0100);
		chk_rd(ADDR_COUNT, 8'h00);
		cyc(120);
		// Live byte is zero now, snapshot holds one
		chk_rd(ADDR_COUNT + 16'h1, 8'h01);
		wr(ADDR_LOAD, 8'h55);
		wr(ADDR_CTRL, 8'h08);
		cyc(5);
		`CHK(o_count_running, 1'b0)
		rd(ADDR_COUNT, rb);
		cyc(200);
		chk_rd(ADDR_COUNT, rb);
		wr(ADDR_KICK, 8'hff);
		cyc(5);
		chk_rd(ADDR_COUNT, rb);
		chk_rd(ADDR_KICK, READ_ZERO);
		chk_rd(ADDR_LOAD, 8'h00);
		wr(ADDR_CTRL, 8'h09);
		cyc(130);
		wr(ADDR_KICK, 8'h01);
		cyc(4);
		chk32(ADDR_COUNT, 32'h0000_0100);
		wr(ADDR_CTRL, 8'h00);
	endtask

	task automatic t_underflow(input logic [7:0] ctrl, input int per,
		input bit by_rst);
		int n;
		arm(ctrl, 32'd2);
		n = 0;
		while (o_sys_reset_req !== 1'b1 && n < 1000) begin
			@(negedge i_clk);
			n++;
		end
		`CHK(n >= 2*per-1 && n <= 2*per+3, 1'b1)
		`CHK(o_reset_event, 1'b1)
		`CHK(o_wr_blocked, 1'b1)
		// Our own chip reset must not wipe the flag
		chip_rst();
		cyc(8);
		`CHK(o_sys_reset_req, 1'b1)
		chk_rd(ADDR_CTRL, 8'h02);
		wr(ADDR_LOAD, 8'h12);
		chk_rd(ADDR_LOAD, 8'hff);
		n = 0;
		while (o_sys_reset_req !== 1'b0 && n < 40) begin
			@(negedge i_clk);
			n++;
		end
		`CHK(o_sys_reset_req, 1'b0)
		if (by_rst) begin
			chip_rst();
			chk_rd(ADDR_CTRL, 8'h00);
		end else begin
			wr(ADDR_CTRL, 8'h00);
			chk_rd(ADDR_CTRL, 8'h02);
			wr(ADDR_CTRL, 8'h02);
			chk_rd(ADDR_CTRL, 8'h00);
		end
		`CHK(o_reset_event, 1'b0)
		`CHK(o_wr_blocked, 1'b0)
	endtask

	task automatic conclude();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		cyc(10);
		i_rst_n <= 1'b1;
		i_por_n <= 1'b1;
		t_reset_values();
		t_counting();
		t_underflow(8'h01, P, 1'b0);
		t_underflow(8'h09, US_CYCLES, 1'b0);
		t_underflow(8'h0d, SIM_CYCLES, 1'b1);
		conclude();
	end

	// Far beyond the run's length
	initial begin
		#(CLK_PERIOD_NS * 20000);
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
